// File: ahi_cfg.svh
`ifndef AHI_CFG_SVH
`define AHI_CFG_SVH

// ==========================================================
// Widths
`define AHI_DATA_W 12
`define AHI_CTRL_W 6
`define AHI_SO_W 16

// ==========================================================
// Control register fields (bit 0 is the LSB)
`define AHI_CTRL_RESET 6'h00
`define AHI_BIT_CODING 0
`define AHI_BIT_STANDBY 1
`define AHI_BIT_SOFT_CONVERT_START 2
`define AHI_BIT_CHAN0 3
`define AHI_BIT_CHAN1 4
`define AHI_BIT_CHAN2 5

// ==========================================================
// Data line positions, parallel write
`define AHI_PIN_CHAN0 8
`define AHI_PIN_CHAN1 7
`define AHI_PIN_CHAN2 6
`define AHI_PIN_SOFT_CONVERT_START 9
`define AHI_PIN_STANDBY 10
`define AHI_PIN_CODING 11

// ==========================================================
// Data line positions, serial mode
`define AHI_PIN_SCLK 5
`define AHI_PIN_TFS 2
`define AHI_PIN_RFS 3
`define AHI_PIN_SDI 4
`define AHI_PIN_SDO 6

// ==========================================================
// Counts
`define AHI_SI_LAST 3'h5
`define AHI_SO_LAST 5'h10

// ==========================================================
// Timing
`define AHI_CLK_PERIOD_NS 50
`define AHI_ACQ_TIME_NS 500
`define AHI_ACQ_CYCLES ((`AHI_ACQ_TIME_NS + `AHI_CLK_PERIOD_NS - 1) / `AHI_CLK_PERIOD_NS)

`endif

// File: ahi_pkg.sv
`default_nettype none

package ahi_pkg;

  // ==========================================================
  // Serial write states, Gray along idle-shift-done
  typedef enum logic [1:0] {
    SI_IDLE = 2'h0,
    SI_SHIFT = 2'h1,
    SI_DONE = 2'h3
  } ahi_si_state_type;

endpackage : ahi_pkg

`default_nettype wire

// File: ahi_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ahi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // ==========================================================
  // Two stages; only the second is read
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : ahi_sync

`default_nettype wire

// File: ahi_delay.sv
`timescale 1ns/1ns
`default_nettype none
`include "ahi_cfg.svh"

module ahi_delay
  import ahi_pkg::*;
#(
  parameter int ACQ_CYCLES = `AHI_ACQ_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_req,
  input wire logic hard_req,
  input wire logic conv_busy,
  output logic hold_start,
  output logic delay_active
);

  localparam logic [11:0] LAST = 12'(ACQ_CYCLES - 1);

  logic [11:0] cnt;

  // ==========================================================
  // Acquisition delay for soft starts, then hold and convert; hard starts hold at once
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 12'h000;
      delay_active <= 1'b0;
      hold_start <= 1'b0;
    end else begin
      hold_start <= 1'b0;
      if (delay_active) begin
        if (cnt == LAST) begin
          delay_active <= 1'b0;
          hold_start <= 1'b1;
        end else begin
          cnt <= cnt + 12'h001;
        end
      end else if (!conv_busy && !hold_start) begin // Busy drops requests
        if (soft_req) begin
          delay_active <= 1'b1;
          cnt <= 12'h000;
        end else if (hard_req) begin
          hold_start <= 1'b1;
        end
      end
    end
  end

endmodule : ahi_delay

`default_nettype wire

// File: ahi_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ahi_cfg.svh"

module ahi_top
  import ahi_pkg::*;
#(
  parameter int ACQ_CYCLES = `AHI_ACQ_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic MODE_SEL,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic CONVERT_START_N,
  input wire logic [`AHI_DATA_W-1:0] DATA_IN,
  output logic [`AHI_DATA_W-1:0] DATA_OUT,
  output logic [`AHI_DATA_W-1:0] DATA_OE,
  input wire logic [`AHI_DATA_W-1:0] CONV_RESULT,
  input wire logic CONV_BUSY,
  output logic HOLD_START,
  output logic DELAY_ACTIVE,
  output logic STANDBY,
  output logic OUTPUT_CODING,
  output logic [2:0] CHAN_SEL,
  output logic [3:0] CHANNEL_NUM
);

  // ==========================================================
  // Helpers
  function automatic logic [`AHI_DATA_W-1:0] ahi_code(
    input logic [`AHI_DATA_W-1:0] r,
    input logic twos
  );
    ahi_code = twos ? {~r[`AHI_DATA_W-1], r[`AHI_DATA_W-2:0]} : r;
  endfunction : ahi_code

  function automatic logic [`AHI_CTRL_W-1:0] ahi_pick(input logic [`AHI_DATA_W-1:0] d);
    logic [`AHI_CTRL_W-1:0] c;
    c = `AHI_CTRL_RESET;
    c[`AHI_BIT_CODING] = d[`AHI_PIN_CODING];
    c[`AHI_BIT_STANDBY] = d[`AHI_PIN_STANDBY];
    c[`AHI_BIT_SOFT_CONVERT_START] = d[`AHI_PIN_SOFT_CONVERT_START];
    c[`AHI_BIT_CHAN0] = d[`AHI_PIN_CHAN0];
    c[`AHI_BIT_CHAN1] = d[`AHI_PIN_CHAN1];
    c[`AHI_BIT_CHAN2] = d[`AHI_PIN_CHAN2];
    ahi_pick = c;
  endfunction : ahi_pick

  // ==========================================================
  // Pin synchronisers
  logic [`AHI_DATA_W-1:0] data_s;
  logic [4:0] pins_s;
  logic par;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic cnv_n;

  ahi_sync #(.W(`AHI_DATA_W), .INIT(12'hfff)) u_data_sync (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .d(DATA_IN),
    .q(data_s)
  );

  ahi_sync #(.W(5), .INIT(5'h1f)) u_pin_sync (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .d({MODE_SEL, CS_N, RD_N, WR_N, CONVERT_START_N}),
    .q(pins_s)
  );

  assign par = pins_s[4];
  assign cs_n = pins_s[3];
  assign rd_n = pins_s[2];
  assign wr_n = pins_s[1];
  assign cnv_n = pins_s[0];

  logic sclk;
  logic tfs_n;
  logic rfs_n;
  logic sdi;
  assign sclk = data_s[`AHI_PIN_SCLK];
  assign tfs_n = data_s[`AHI_PIN_TFS];
  assign rfs_n = data_s[`AHI_PIN_RFS];
  assign sdi = data_s[`AHI_PIN_SDI];

  // ==========================================================
  // Edge detection on synchronised levels
  logic sclk_q;
  logic tfs_q;
  logic rfs_q;
  logic wr_q;
  logic cnv_q;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sclk_q <= 1'b1; // Matches idle-high sync value, no false edge
      tfs_q <= 1'b1;
      rfs_q <= 1'b1;
      wr_q <= 1'b1;
      cnv_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      tfs_q <= tfs_n;
      rfs_q <= rfs_n;
      wr_q <= wr_n;
      cnv_q <= cnv_n;
    end
  end

  logic sclk_fall;
  logic sclk_rise;
  logic tfs_fall;
  logic tfs_rise;
  logic rfs_fall;
  logic wr_rise;
  logic cnv_rise;
  assign sclk_fall = sclk_q & ~sclk;
  assign sclk_rise = ~sclk_q & sclk;
  assign tfs_fall = tfs_q & ~tfs_n;
  assign tfs_rise = ~tfs_q & tfs_n;
  assign rfs_fall = rfs_q & ~rfs_n;
  assign wr_rise = ~wr_q & wr_n;
  assign cnv_rise = ~cnv_q & cnv_n;

  // ==========================================================
  // Parallel write capture
  logic [`AHI_CTRL_W-1:0] wr_cap;
  logic wr_armed;
  logic par_commit;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      wr_cap <= `AHI_CTRL_RESET;
      wr_armed <= 1'b0;
    end else if (par && !cs_n && !wr_n) begin
      wr_cap <= ahi_pick(data_s); // Track data until the strobe rises
      wr_armed <= 1'b1;
    end else if (wr_rise || !par) begin
      wr_armed <= 1'b0;
    end
  end

  assign par_commit = par & wr_armed & wr_rise;

  // ==========================================================
  // Serial write
  ahi_si_state_type si_state;
  logic [2:0] si_cnt;
  logic [`AHI_CTRL_W-2:0] si_sh;
  logic ser_commit;
  logic ser_abort;
  logic [`AHI_CTRL_W-1:0] ser_word;

  assign ser_word = {si_sh, sdi}; // First bit lands in the MSB
  assign ser_commit = (si_state == SI_SHIFT) & ~tfs_rise & sclk_fall
                    & (si_cnt == `AHI_SI_LAST);
  assign ser_abort = (si_state == SI_SHIFT) & tfs_rise;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || par) begin
      si_state <= SI_IDLE;
      si_cnt <= 3'h0;
      si_sh <= '0;
    end else begin
      case (si_state)
        SI_IDLE: begin
          if (tfs_fall) begin
            si_state <= SI_SHIFT;
            si_cnt <= 3'h0;
          end
        end
        SI_SHIFT: begin
          if (tfs_rise) begin
            si_state <= SI_IDLE; // Short frame is dropped
          end else if (sclk_fall) begin
            si_sh <= ser_word[`AHI_CTRL_W-2:0];
            si_cnt <= si_cnt + 3'h1;
            if (si_cnt == `AHI_SI_LAST) begin
              si_state <= SI_DONE;
            end
          end
        end
        SI_DONE: begin
          if (tfs_rise) begin // Extra bits ignored meanwhile
            si_state <= SI_IDLE;
          end
        end
        default: begin
          si_state <= SI_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Control register
  logic [`AHI_CTRL_W-1:0] ctrl;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl <= `AHI_CTRL_RESET;
    end else if (par_commit) begin
      ctrl <= wr_cap;
    end else if (ser_commit) begin
      ctrl <= ser_word;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      STANDBY <= 1'b0;
      OUTPUT_CODING <= 1'b0;
      CHAN_SEL <= 3'h0;
      CHANNEL_NUM <= 4'h1;
    end else begin
      STANDBY <= ctrl[`AHI_BIT_STANDBY];
      OUTPUT_CODING <= ctrl[`AHI_BIT_CODING];
      CHAN_SEL <= ctrl[`AHI_BIT_CHAN2:`AHI_BIT_CHAN0];
      CHANNEL_NUM <= {1'b0, ctrl[`AHI_BIT_CHAN2:`AHI_BIT_CHAN0]} + 4'h1;
    end
  end

  // ==========================================================
  // Conversion starts
  logic soft_req;
  logic hard_req;

  // A write with the bit set retriggers even if already set, unless busy or a delay is running
  assign soft_req = (par_commit & wr_cap[`AHI_BIT_SOFT_CONVERT_START])
                  | (ser_commit & ser_word[`AHI_BIT_SOFT_CONVERT_START])
                  | (ser_abort & ctrl[`AHI_BIT_SOFT_CONVERT_START]);
  assign hard_req = cnv_rise & ~ctrl[`AHI_BIT_SOFT_CONVERT_START];

  ahi_delay #(.ACQ_CYCLES(ACQ_CYCLES)) u_delay (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .soft_req(soft_req),
    .hard_req(hard_req),
    .conv_busy(CONV_BUSY),
    .hold_start(HOLD_START),
    .delay_active(DELAY_ACTIVE)
  );

  // ==========================================================
  // Serial read
  logic [`AHI_SO_W-1:0] so_sh;
  logic [4:0] so_cnt;
  logic [`AHI_DATA_W-1:0] coded;

  assign coded = ahi_code(CONV_RESULT, ctrl[`AHI_BIT_CODING]);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || par) begin
      so_sh <= '0;
      so_cnt <= 5'h0;
    end else if (rfs_fall) begin
      so_sh <= {ctrl[`AHI_BIT_CODING], ctrl[`AHI_BIT_CHAN2:`AHI_BIT_CHAN0], coded};
      so_cnt <= 5'h0;
    end else if (!rfs_n && sclk_fall && so_cnt != `AHI_SO_LAST) begin
      so_cnt <= so_cnt + 5'h1;
    end else if (!rfs_n && sclk_rise && so_cnt != 5'h0 && so_cnt != `AHI_SO_LAST) begin
      so_sh <= {so_sh[`AHI_SO_W-2:0], 1'b0}; // Change on rise, sampled on fall
    end
  end

  // ==========================================================
  // Pin drivers
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      DATA_OUT <= '0;
      DATA_OE <= '0;
    end else if (par) begin
      DATA_OUT <= coded;
      DATA_OE <= (!cs_n && !rd_n) ? '1 : '0;
    end else begin
      DATA_OUT <= '0;
      DATA_OUT[`AHI_PIN_SDO] <= so_sh[`AHI_SO_W-1];
      DATA_OE <= '0;
      DATA_OE[`AHI_PIN_SDO] <= ~rfs_n;
    end
  end

endmodule : ahi_top

`default_nettype wire

// File: ahi_props.sv
`timescale 1ns/1ns
`default_nettype none

module ahi_props #(
  parameter int ACQ_CYCLES = 10
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic MODE_SEL,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [11:0] DATA_OUT,
  input wire logic [11:0] DATA_OE,
  input wire logic [11:0] CONV_RESULT,
  input wire logic CONV_BUSY,
  input wire logic HOLD_START,
  input wire logic DELAY_ACTIVE,
  input wire logic STANDBY,
  input wire logic OUTPUT_CODING,
  input wire logic [2:0] CHAN_SEL,
  input wire logic [3:0] CHANNEL_NUM
);
  // ========
  // Delay run length, too long for a repetition
  logic [7:0] run_len;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !DELAY_ACTIVE) begin
      run_len <= 8'h00;
    end else begin
      run_len <= run_len + 8'h01;
    end
  end

  // ========
  // Checks
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  sequence rd_seq;
    (MODE_SEL && !CS_N && !RD_N) [*4];
  endsequence
  sequence idle_seq;
    (MODE_SEL && CS_N) [*4];
  endsequence

  idle_oe_a: assert property (idle_seq |-> DATA_OE == 12'h000)
    else $error("data lines driven while idle");
  rd_oe_a: assert property (rd_seq |-> DATA_OE == 12'hfff)
    else $error("read does not drive all lines");
  rd_data_a: assert property (rd_seq |-> DATA_OUT ==
    {$past(CONV_RESULT[11]) ^ $past(OUTPUT_CODING), $past(CONV_RESULT[10:0])})
    else $error("read data coding wrong");
  serial_oe_a: assert property ((!MODE_SEL) [*4] |-> (DATA_OE & 12'hfbf) == 12'h000)
    else $error("serial mode drives a non-output line");
  chan_num_a: assert property (CHANNEL_NUM == {1'b0, CHAN_SEL} + 4'h1)
    else $error("channel number wrong");
  hold_pulse_a: assert property (HOLD_START |=> !HOLD_START)
    else $error("hold start longer than one cycle");
  delay_len_a: assert property ($fell(DELAY_ACTIVE) |-> HOLD_START && run_len == ACQ_CYCLES)
    else $error("delay pulse length wrong");
  delay_start_a: assert property ($rose(DELAY_ACTIVE) |-> !$past(CONV_BUSY))
    else $error("delay started while busy");
  ctrl_hold_a: assert property ((MODE_SEL && WR_N) [*6] |->
    $stable({STANDBY, OUTPUT_CODING, CHAN_SEL}))
    else $error("control changed without a write");
endmodule : ahi_props

bind ahi_top ahi_props #(.ACQ_CYCLES(ACQ_CYCLES)) u_props (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .MODE_SEL(MODE_SEL), .CS_N(CS_N), .RD_N(RD_N),
  .WR_N(WR_N), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .CONV_RESULT(CONV_RESULT),
  .CONV_BUSY(CONV_BUSY), .HOLD_START(HOLD_START), .DELAY_ACTIVE(DELAY_ACTIVE),
  .STANDBY(STANDBY), .OUTPUT_CODING(OUTPUT_CODING), .CHAN_SEL(CHAN_SEL),
  .CHANNEL_NUM(CHANNEL_NUM));

`default_nettype wire

// File: ahi_host.sv
`timescale 1ns/1ns
`default_nettype none

module ahi_host (
  input wire logic clk,
  input wire logic sdo,
  output logic [11:0] drv
);
  // ========
  // Serial host, clock idles high between frames
  logic sclk = 1'b1;
  logic sync_n = 1'b1;
  logic sdi = 1'b0;
  // Unused lines toggle so no stale level passes; test lines low
  // Both syncs tied, one frame reads and writes
  assign drv = {{6{sclk}}, sclk, sdi, sync_n, sync_n, 2'b00};

  task automatic frame(input int n, input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk);
    #1;
    sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = w[15-i];
      repeat (4) @(posedge clk);
      #1;
      r = {r[14:0], sdo};
      sclk = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      sclk = 1'b1;
    end
    repeat (4) @(posedge clk);
    #1;
    sync_n = 1'b1;
    sdi = ~sdi;
    repeat (20) @(posedge clk);
    #1;
  endtask : frame
endmodule : ahi_host

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic cvs_n = 1'b1;
  logic busy = 1'b0;
  logic [11:0] crs = 12'h000;
  logic [11:0] pdrv = 12'h000;
  logic [11:0] hdrv, bus, d_out, d_oe;
  logic hold, dly, stby, cod;
  logic [2:0] chs;
  logic [3:0] chn;
  logic [15:0] starts = 16'h0000;
  logic [15:0] es = 16'h0000;
  logic [15:0] cfg_out;
  logic [31:0] seed = 32'haf72;
  logic [31:0] rv;
  int fails = 0;
  int checked = 0;
  int ss = 0;
  localparam int ACQ = 3;
  logic [15:0] dcyc = 16'h0000;

  // ========
  // Wiring, device enable wins on a line
  assign cfg_out = {7'h00, stby, cod, chs, chn};
  assign bus = (d_oe & d_out) | (~d_oe & (mode ? pdrv : hdrv));
  always #25 clk = ~clk;
  always @(posedge clk) if (hold) starts <= starts + 16'h0001;
  always @(posedge clk) if (dly) dcyc <= dcyc + 16'h0001;

  ahi_top #(.ACQ_CYCLES(ACQ)) uut (
    .SYS_CLK(clk), .SYS_RST(rst), .MODE_SEL(mode), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
    .CONVERT_START_N(cvs_n), .DATA_IN(bus), .DATA_OUT(d_out), .DATA_OE(d_oe),
    .CONV_RESULT(crs), .CONV_BUSY(busy), .HOLD_START(hold), .DELAY_ACTIVE(dly),
    .STANDBY(stby), .OUTPUT_CODING(cod), .CHAN_SEL(chs), .CHANNEL_NUM(chn));
  ahi_host host (.clk(clk), .sdo(bus[6]), .drv(hdrv));

  // ========
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [11:0] code(input logic [11:0] r, input logic t);
    return {r[11] ^ t, r[10:0]};
  endfunction : code
  function automatic logic [15:0] cfg_exp(input logic [5:0] c);
    return {7'h00, c[1], c[0], c[5:3], {1'b0, c[5:3]} + 4'h1};
  endfunction : cfg_exp
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic pwrite(input logic [5:0] c);
    rv = rnd();
    pdrv = {c[0], c[1], c[2], c[3], c[4], c[5], rv[5:0]};
    cs_n = 1'b0;
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(1);
    cs_n = 1'b1;
    step(20);
  endtask : pwrite
  task automatic pread(input logic t);
    rv = rnd();
    crs = rv[11:0];
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(4);
    chk({4'h0, d_oe}, 16'h0fff);
    chk({4'h0, d_out}, {4'h0, code(crs, t)});
    rd_n = 1'b1;
    cs_n = 1'b1;
    step(4);
    chk({4'h0, d_oe}, 16'h0000);
  endtask : pread
  task automatic hw_pulse();
    cvs_n = 1'b0;
    step(3);
    cvs_n = 1'b1;
    step(20);
  endtask : hw_pulse

  // ========
  // Watchdog, over ten times the expected run
  initial begin
    #400000;
    fails++;
    complete_run();
  end

  // ========
  // Main sequence
  initial begin
    logic [5:0] c;
    logic [15:0] w;
    step(4);
    rst = 1'b0;
    step(3);
    chk(cfg_out, cfg_exp(6'h00));
    for (int i = 0; i < 8; i++) begin
      rv = rnd();
      c = {i[2:0], rv[2:0]};
      if (c[2]) begin
        es++;
        ss++;
      end
      pwrite(c);
      chk(cfg_out, cfg_exp(c));
      chk(starts, es);
      pread(c[0]);
    end
    pwrite(6'h04);
    es++;
    ss++;
    hw_pulse();
    chk(starts, es);
    pwrite(6'h00);
    hw_pulse();
    es++;
    chk(starts, es);
    busy = 1'b1;
    pwrite(6'h04);
    busy = 1'b0;
    chk(starts, es);
    mode = 1'b0;
    step(4);
    rv = rnd();
    crs = rv[11:0];
    es++;
    ss++;
    host.frame(16, {6'h2d, 10'h155}, w);
    chk(w, {4'h0, code(crs, 1'b0)});
    chk(cfg_out, cfg_exp(6'h2d));
    es++;
    ss++;
    host.frame(16, {6'h2d, 10'h000}, w);
    chk(w, {4'hd, code(crs, 1'b1)});
    es++;
    ss++;
    host.frame(3, {6'h12, 10'h000}, w);
    chk(cfg_out, cfg_exp(6'h2d));
    chk(starts, es);
    chk(dcyc, 16'(ss * ACQ));
    complete_run();
  end
endmodule : tb

`default_nettype wire
